// ---- src/opmode_params.svh ----
// Vector address and width constants for the operating mode controller
// Assumes inclusion by bare name from design files
`ifndef OPMODE_PARAMS_SVH
`define OPMODE_PARAMS_SVH
`define RESET_VECTOR_ADDR   16'hfffe
`define CMD_CLASS_W         3
`define WAKE_SRC_W          8
`define VEC_W               16
`endif

// ---- src/opmode_pkg.sv ----
// Types for the operating mode controller
// Assumes no other package
package opmode_pkg;
   typedef enum logic [4:0] {
      RUN_ST   = 5'h01,
      SOFTWARE_BREAKPOINT_INSTRUCTION_ST  = 5'h02,
      WAIT_ST  = 5'h04,
      STOP3_ST = 5'h08,
      STOP2_ST = 5'h10
   } mode_type;
   typedef enum logic [2:0] {
      CMD_MEM      = 3'h0,
      CMD_MEM_STAT = 3'h1,
      CMD_REG_BDC  = 3'h2,
      CMD_BACKGND  = 3'h3,
      CMD_CPU_REG  = 3'h4,
      CMD_TRACE    = 3'h5,
      CMD_GO       = 3'h6
   } cmd_type;
endpackage

// ---- src/pin_sync.sv ----
// Three-flop pin synchroniser with agreement filter
// Assumes one clock, synchronous active high reset
`timescale 1ns/1ps
module pin_sync (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic pin_i,
   output logic      level_o
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   // Runs through reset so the level is current when reset is released
   always_ff @(posedge clk_i) begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (reset_i || (s2_ff == s3_ff)) begin
         level_o <= s3_ff;
      end
   end
endmodule // pin_sync

// ---- src/operating_mode_controller.sv ----
// Operating mode controller: run, background, wait, stop3, stop2
// Assumes CPU, debug serial engine and clock generator outside
//
// How it works
// - Pin high at release: run, reset vector
// - Five events enter active background mode
// - Background mode holds CPU suspended
// - Non-intrusive commands accepted in run/background
// - CPU register, trace, go: background only
// - Wait stops CPU clock, clears I bit
// - Interrupt leaves wait, stacking follows
// - Wait accepts background commands only, flags status commands
// - Background command wakes wait into background
// - Stop without permit gives illegal-opcode reset
// - Debug permit or LOWVOLT_DETECTOR-in-stop selects stop3
// - Otherwise partial-powerdown select picks stop3/stop2
// - Stop halts clocks except kept references
// - Stop3 preserves registers, RAM, pins
// - Reset or async pin interrupt exits stop3
// - LOWVOLT_DETECTOR, LOWVOLT_WARNING, ADC, RTC, SCI also exit stop3
// - Reset exit fetches reset, interrupt its vector
// - LOWVOLT_DETECTOR-in-stop keeps regulator active
// - Background entry from run needs debug permit
// - Debug permit keeps debug clocks, full regulation
// - Stop rejects commands, stop3 flags status; background wakes stop3 if permitted
// - Stop2 wake sets flag, latches pins until ack
`timescale 1ns/1ps
`include "opmode_params.svh"
module operating_mode_controller (
   input  wire logic                    clk_i,
   input  wire logic                    reset_i,
   input  wire logic                    debug_mode_select_pin_i,
   input  wire logic                    wait_instr_i,
   input  wire logic                    stop_instr_i,
   input  wire logic                    software_breakpoint_instruction_instr_i,
   input  wire logic                    bdc_break_i,
   input  wire logic                    trace_break_i,
   input  wire logic                    cmd_valid_i,
   input  wire logic [`CMD_CLASS_W-1:0] cmd_class_i,
   input  wire logic                    irq_pending_i,
   input  wire logic                    ext_irq_pin_i,
   input  wire logic [7:0]              port_a_pin_interrupts_i,
   input  wire logic [7:0]              port_b_pin_interrupts_i,
   input  wire logic [7:0]              port_d_pin_interrupts_i,
   input  wire logic                    lvd_reset_i,
   input  wire logic                    lvw_irq_i,
   input  wire logic                    adc_irq_i,
   input  wire logic                    rtc_irq_i,
   input  wire logic                    sci_rx_irq_i,
   input  wire logic [`VEC_W-1:0]       irq_vector_i,
   input  wire logic                    stop_permit_i,
   input  wire logic                    debug_permit_i,
   input  wire logic                    lowvolt_detect_on_i,
   input  wire logic                    lowvolt_in_stop_on_i,
   input  wire logic                    partial_powerdown_select_i,
   input  wire logic                    partial_powerdown_ack_i,
   input  wire logic                    ref_clk_keep_i,
   output logic [4:0]                   mode_o,
   output logic                         cpu_clk_en_o,
   output logic                         cpu_suspend_o,
   output logic                         clear_i_bit_o,
   output logic                         stack_start_o,
   output logic                         sys_clk_en_o,
   output logic                         ref_clk_en_o,
   output logic                         bdc_clk_en_o,
   output logic                         regulator_full_o,
   output logic                         illegal_op_reset_o,
   output logic                         cpu_reset_o,
   output logic                         fetch_vector_o,
   output logic [`VEC_W-1:0]            fetch_addr_o,
   output logic                         cmd_accept_o,
   output logic                         cmd_reject_o,
   output logic                         cmd_stat_err_o,
   output logic                         pin_latch_o,
   output logic                         partial_powerdown_flag_o
);
   // ==========================================================
   // Pin synchronisers
   logic mode_pin_s;
   logic ext_irq_s;
   logic [23:0] pin_irq_s;
   logic [23:0] pin_irq_raw;
   assign pin_irq_raw = {port_d_pin_interrupts_i, port_b_pin_interrupts_i,
                         port_a_pin_interrupts_i};
   pin_sync u_mode_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .pin_i   (debug_mode_select_pin_i),
      .level_o (mode_pin_s)
   );
   pin_sync u_irq_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .pin_i   (ext_irq_pin_i),
      .level_o (ext_irq_s)
   );
   genvar gi;
   generate
      for (gi = 0; gi < 24; gi = gi + 1) begin : g_pin
         pin_sync u_pin_sync (
            .clk_i   (clk_i),
            .reset_i (reset_i),
            .pin_i   (pin_irq_raw[gi]),
            .level_o (pin_irq_s[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Command classification
   function automatic logic is_non_intrusive(input logic [`CMD_CLASS_W-1:0] c);
      is_non_intrusive = (c == opmode_pkg::CMD_MEM) || (c == opmode_pkg::CMD_MEM_STAT) ||
                         (c == opmode_pkg::CMD_REG_BDC) || (c == opmode_pkg::CMD_BACKGND);
   endfunction
   function automatic logic is_software_breakpoint_instruction_only(input logic [`CMD_CLASS_W-1:0] c);
      is_software_breakpoint_instruction_only = (c == opmode_pkg::CMD_CPU_REG) || (c == opmode_pkg::CMD_TRACE) ||
                     (c == opmode_pkg::CMD_GO);
   endfunction

   // ==========================================================
   // Mode state
   opmode_pkg::mode_type mode_ff;
   opmode_pkg::mode_type nxt_mode;
   logic start_ff;
   logic wake_ff;
   logic stop_dbg_ff;
   logic stop_lvd_ff;
   logic software_breakpoint_instruction_cmd;
   logic stop3_wake_irq;
   logic stop3_wake_rst;

   assign software_breakpoint_instruction_cmd = cmd_valid_i && (cmd_class_i == opmode_pkg::CMD_BACKGND);
   assign stop3_wake_irq = ext_irq_s || (|pin_irq_s) || lvw_irq_i || adc_irq_i ||
                           rtc_irq_i || sci_rx_irq_i;
   assign stop3_wake_rst = lvd_reset_i;

   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         opmode_pkg::RUN_ST: begin
            if (wait_instr_i) begin
               nxt_mode = opmode_pkg::WAIT_ST;
            end else if (stop_instr_i && stop_permit_i) begin
               if (debug_permit_i || (lowvolt_detect_on_i && lowvolt_in_stop_on_i)) begin
                  nxt_mode = opmode_pkg::STOP3_ST;
               end else if (partial_powerdown_select_i) begin
                  nxt_mode = opmode_pkg::STOP2_ST;
               end else begin
                  nxt_mode = opmode_pkg::STOP3_ST;
               end
            end else if (debug_permit_i &&
                         (software_breakpoint_instruction_cmd || software_breakpoint_instruction_instr_i || bdc_break_i || trace_break_i)) begin
               nxt_mode = opmode_pkg::SOFTWARE_BREAKPOINT_INSTRUCTION_ST;
            end
         end
         opmode_pkg::SOFTWARE_BREAKPOINT_INSTRUCTION_ST: begin
            if (cmd_valid_i && (cmd_class_i == opmode_pkg::CMD_GO)) begin
               nxt_mode = opmode_pkg::RUN_ST;
            end
         end
         opmode_pkg::WAIT_ST: begin
            if (software_breakpoint_instruction_cmd) begin
               nxt_mode = opmode_pkg::SOFTWARE_BREAKPOINT_INSTRUCTION_ST;
            end else if (irq_pending_i) begin
               nxt_mode = opmode_pkg::RUN_ST;
            end
         end
         opmode_pkg::STOP3_ST: begin
            if (software_breakpoint_instruction_cmd && stop_dbg_ff) begin
               nxt_mode = opmode_pkg::SOFTWARE_BREAKPOINT_INSTRUCTION_ST;
            end else if (stop3_wake_rst) begin
               nxt_mode = opmode_pkg::RUN_ST;
            end else if (stop3_wake_irq) begin
               nxt_mode = opmode_pkg::RUN_ST;
            end
         end
         opmode_pkg::STOP2_ST: begin
            if (rtc_irq_i) begin
               nxt_mode = opmode_pkg::RUN_ST;
            end
         end
         default: begin
            nxt_mode = opmode_pkg::RUN_ST;
         end
      endcase
      if (start_ff) begin
         nxt_mode = mode_pin_s ? opmode_pkg::RUN_ST : opmode_pkg::SOFTWARE_BREAKPOINT_INSTRUCTION_ST;
      end
   end

   // Start-up: mode pin sampled one edge after release
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         start_ff <= 1'b1;
         mode_ff  <= opmode_pkg::RUN_ST;
      end else begin
         start_ff <= 1'b0;
         mode_ff  <= nxt_mode;
      end
   end

   // Stop options captured at stop entry
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         stop_dbg_ff <= 1'b0;
         stop_lvd_ff <= 1'b0;
      end else if (mode_ff == opmode_pkg::RUN_ST && stop_instr_i && stop_permit_i) begin
         stop_dbg_ff <= debug_permit_i;
         stop_lvd_ff <= lowvolt_detect_on_i && lowvolt_in_stop_on_i;
      end
   end

   // ==========================================================
   // Clocks, regulator, reset and vectors
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cpu_clk_en_o       <= 1'b0;
         cpu_suspend_o      <= 1'b1;
         sys_clk_en_o       <= 1'b1;
         ref_clk_en_o       <= 1'b1;
         bdc_clk_en_o       <= 1'b1;
         regulator_full_o   <= 1'b1;
         mode_o             <= 5'h01;
      end else begin
         mode_o        <= nxt_mode;
         cpu_clk_en_o  <= (nxt_mode == opmode_pkg::RUN_ST) && !start_ff;
         cpu_suspend_o <= (nxt_mode == opmode_pkg::SOFTWARE_BREAKPOINT_INSTRUCTION_ST) || start_ff;
         sys_clk_en_o  <= !(nxt_mode == opmode_pkg::STOP3_ST ||
                            nxt_mode == opmode_pkg::STOP2_ST);
         if (nxt_mode == opmode_pkg::STOP3_ST || nxt_mode == opmode_pkg::STOP2_ST) begin
            ref_clk_en_o     <= ref_clk_keep_i;
            bdc_clk_en_o     <= (mode_ff == opmode_pkg::RUN_ST) ? debug_permit_i
                                                                : stop_dbg_ff;
            regulator_full_o <= (mode_ff == opmode_pkg::RUN_ST) ?
                                (debug_permit_i ||
                                 (lowvolt_detect_on_i && lowvolt_in_stop_on_i))
                                : (stop_dbg_ff || stop_lvd_ff);
         end else begin
            ref_clk_en_o     <= 1'b1;
            bdc_clk_en_o     <= 1'b1;
            regulator_full_o <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         illegal_op_reset_o <= 1'b0;
         cpu_reset_o        <= 1'b0;
         clear_i_bit_o      <= 1'b0;
         stack_start_o      <= 1'b0;
         fetch_vector_o     <= 1'b0;
         fetch_addr_o       <= `RESET_VECTOR_ADDR;
         wake_ff            <= 1'b0;
      end else begin
         illegal_op_reset_o <= mode_ff == opmode_pkg::RUN_ST && stop_instr_i &&
                               !stop_permit_i && !wait_instr_i;
         clear_i_bit_o  <= mode_ff == opmode_pkg::RUN_ST && wait_instr_i;
         stack_start_o  <= mode_ff == opmode_pkg::WAIT_ST && !software_breakpoint_instruction_cmd &&
                           irq_pending_i;
         wake_ff        <= 1'b0;
         cpu_reset_o    <= 1'b0;
         fetch_vector_o <= 1'b0;
         if (start_ff && mode_pin_s) begin
            fetch_vector_o <= 1'b1;
            fetch_addr_o   <= `RESET_VECTOR_ADDR;
         end else if (mode_ff == opmode_pkg::STOP3_ST && !(software_breakpoint_instruction_cmd && stop_dbg_ff)) begin
            if (stop3_wake_rst) begin
               cpu_reset_o    <= 1'b1;
               fetch_vector_o <= 1'b1;
               fetch_addr_o   <= `RESET_VECTOR_ADDR;
            end else if (stop3_wake_irq) begin
               fetch_vector_o <= 1'b1;
               fetch_addr_o   <= irq_vector_i;
            end
         end else if (mode_ff == opmode_pkg::STOP2_ST && rtc_irq_i) begin
            cpu_reset_o    <= 1'b1;
            fetch_vector_o <= 1'b1;
            fetch_addr_o   <= `RESET_VECTOR_ADDR;
            wake_ff        <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Partial powerdown flag and pin latch
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         partial_powerdown_flag_o <= 1'b0;
         pin_latch_o              <= 1'b0;
      end else if (nxt_mode == opmode_pkg::STOP2_ST || wake_ff) begin
         pin_latch_o              <= 1'b1;
         partial_powerdown_flag_o <= wake_ff || partial_powerdown_flag_o;
      end else if (partial_powerdown_ack_i) begin
         pin_latch_o              <= 1'b0;
         partial_powerdown_flag_o <= 1'b0;
      end
   end

   // ==========================================================
   // Debug command gate
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cmd_accept_o   <= 1'b0;
         cmd_reject_o   <= 1'b0;
         cmd_stat_err_o <= 1'b0;
      end else begin
         cmd_accept_o   <= 1'b0;
         cmd_reject_o   <= 1'b0;
         cmd_stat_err_o <= 1'b0;
         if (cmd_valid_i && !start_ff) begin
            case (mode_ff)
               opmode_pkg::RUN_ST: begin
                  cmd_accept_o <= is_non_intrusive(cmd_class_i);
                  cmd_reject_o <= !is_non_intrusive(cmd_class_i);
               end
               opmode_pkg::SOFTWARE_BREAKPOINT_INSTRUCTION_ST: begin
                  cmd_accept_o <= is_non_intrusive(cmd_class_i) ||
                                  is_software_breakpoint_instruction_only(cmd_class_i);
                  cmd_reject_o <= !(is_non_intrusive(cmd_class_i) ||
                                    is_software_breakpoint_instruction_only(cmd_class_i));
               end
               opmode_pkg::WAIT_ST, opmode_pkg::STOP3_ST: begin
                  cmd_stat_err_o <= cmd_class_i == opmode_pkg::CMD_MEM_STAT;
                  cmd_accept_o   <= software_breakpoint_instruction_cmd &&
                                    (mode_ff == opmode_pkg::WAIT_ST || stop_dbg_ff);
                  cmd_reject_o   <= !(cmd_class_i == opmode_pkg::CMD_MEM_STAT) &&
                                    !(software_breakpoint_instruction_cmd && (mode_ff == opmode_pkg::WAIT_ST ||
                                                   stop_dbg_ff));
               end
               default: begin
                  cmd_reject_o <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule // operating_mode_controller

// ---- verif/opmode_checker_assertions.sv ----
// Concurrent checks on the operating mode controller ports
// Assumes one clock domain and a synchronous active high reset
`timescale 1ns/1ps
`include "opmode_params.svh"
module opmode_checker (
   input  wire logic                    clk_i,
   input  wire logic                    reset_i,
   input  wire logic                    wait_instr_i,
   input  wire logic                    stop_instr_i,
   input  wire logic                    software_breakpoint_instruction_instr_i,
   input  wire logic                    cmd_valid_i,
   input  wire logic [`CMD_CLASS_W-1:0] cmd_class_i,
   input  wire logic                    irq_pending_i,
   input  wire logic                    rtc_irq_i,
   input  wire logic                    stop_permit_i,
   input  wire logic                    debug_permit_i,
   input  wire logic                    partial_powerdown_select_i,
   input  wire logic [4:0]              mode_o,
   input  wire logic                    clear_i_bit_o,
   input  wire logic                    stack_start_o,
   input  wire logic                    sys_clk_en_o,
   input  wire logic                    bdc_clk_en_o,
   input  wire logic                    regulator_full_o,
   input  wire logic                    illegal_op_reset_o,
   input  wire logic                    cpu_reset_o,
   input  wire logic [`VEC_W-1:0]       fetch_addr_o,
   input  wire logic                    cmd_stat_err_o,
   input  wire logic                    cmd_reject_o,
   input  wire logic                    partial_powerdown_flag_o
);
   // ==========
   // Properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   wire go_stop = mode_o == 5'h01 && stop_instr_i && !wait_instr_i;
   one_hot_a: assert property ($onehot(mode_o))
      else $error("mode not one-hot");
   stop_refused_a: assert property (go_stop && !stop_permit_i |=> illegal_op_reset_o
      && mode_o == 5'h01) else $error("stop without permit");
   stop3_debug_a: assert property (go_stop && stop_permit_i && debug_permit_i |=>
      mode_o == 5'h08 && bdc_clk_en_o && regulator_full_o) else $error("stop3 debug");
   stop2_entry_a: assert property (mode_o == 5'h10 |-> !sys_clk_en_o && !regulator_full_o)
      else $error("stop2 clocks");
   software_breakpoint_instruction_permit_a: assert property (mode_o == 5'h01 && software_breakpoint_instruction_instr_i && !debug_permit_i &&
      !wait_instr_i && !stop_instr_i |=> mode_o == 5'h01) else $error("software_breakpoint_instruction entry");
   wait_entry_a: assert property (mode_o == 5'h01 && wait_instr_i |=> mode_o == 5'h04
      && clear_i_bit_o ##1 !clear_i_bit_o) else $error("wait entry");
   wait_exit_a: assert property (mode_o == 5'h04 && irq_pending_i && !cmd_valid_i |=>
      mode_o == 5'h01 && stack_start_o) else $error("wait exit");
   wait_status_a: assert property (mode_o == 5'h04 && cmd_valid_i && cmd_class_i == 3'h1
      |=> cmd_stat_err_o) else $error("wait status");
   stop2_reject_a: assert property (mode_o == 5'h10 && cmd_valid_i && !rtc_irq_i |=>
      cmd_reject_o && mode_o == 5'h10) else $error("stop2 command");
   stop2_wake_a: assert property (mode_o == 5'h10 && rtc_irq_i |=> cpu_reset_o &&
      fetch_addr_o == 16'hfffe ##1 partial_powerdown_flag_o) else $error("stop2 wake");
   cover property (mode_o == 5'h10 && rtc_irq_i);
   cover property (mode_o == 5'h04 && irq_pending_i);
   cover property (illegal_op_reset_o);
endmodule // opmode_checker

bind operating_mode_controller opmode_checker chk_u (.clk_i, .reset_i, .wait_instr_i,
   .stop_instr_i, .software_breakpoint_instruction_instr_i, .cmd_valid_i, .cmd_class_i, .irq_pending_i, .rtc_irq_i,
   .stop_permit_i, .debug_permit_i, .partial_powerdown_select_i, .mode_o, .clear_i_bit_o,
   .stack_start_o, .sys_clk_en_o, .bdc_clk_en_o, .regulator_full_o, .illegal_op_reset_o,
   .cpu_reset_o, .fetch_addr_o, .cmd_stat_err_o, .cmd_reject_o, .partial_powerdown_flag_o);

// ---- verif/debug_host.sv ----
// Background debug host model issuing one command per call
// Assumes calls are made at the falling edge of the clock
`timescale 1ns/1ps
module debug_host #(
   parameter int GAP = 0
) (
   input  wire logic       clk_i,
   output logic            cmd_valid_o,
   output logic [2:0]      cmd_class_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_class_o = 3'h7;
   end
   // Released class lines show the inverse of the last class
   task automatic send(input logic [2:0] c);
      repeat (GAP + 1) @(negedge clk_i);
      cmd_valid_o = 1'b1;
      cmd_class_o = c;
      @(negedge clk_i);
      cmd_valid_o = 1'b0;
      cmd_class_o = ~c;
   endtask
endmodule // debug_host

// ---- verif/test_operating_mode_controller.sv ----
// Self-checking bench for the operating mode controller
// Assumes the debug host model and the bound checker
`timescale 1ns/1ps
`include "opmode_params.svh"
module test_operating_mode_controller;
   logic clk_i, reset_i, debug_mode_select_pin_i, wait_instr_i, stop_instr_i, software_breakpoint_instruction_instr_i;
   logic bdc_break_i, trace_break_i, irq_pending_i, ext_irq_pin_i, lvd_reset_i, lvw_irq_i;
   logic adc_irq_i, rtc_irq_i, sci_rx_irq_i, ref_clk_keep_i, stop_permit_i, debug_permit_i;
   logic lowvolt_detect_on_i, lowvolt_in_stop_on_i, partial_powerdown_select_i, cmd_valid_i;
   logic partial_powerdown_ack_i, cpu_clk_en_o, cpu_suspend_o, clear_i_bit_o, stack_start_o;
   logic sys_clk_en_o, ref_clk_en_o, bdc_clk_en_o, regulator_full_o, illegal_op_reset_o, d0;
   logic cpu_reset_o, fetch_vector_o, cmd_accept_o, cmd_reject_o, cmd_stat_err_o, pin_latch_o;
   logic partial_powerdown_flag_o;
   logic [2:0]  cmd_class_i;
   logic [7:0]  port_a_pin_interrupts_i, port_b_pin_interrupts_i, port_d_pin_interrupts_i;
   logic [15:0] irq_vector_i, fetch_addr_o;
   logic [4:0]  mode_o, exp;
   int          fails, n_checks, seed, i, k;
   operating_mode_controller dut_u (.*);
   debug_host #(.GAP(1)) host_u (.clk_i, .cmd_valid_o(cmd_valid_i), .cmd_class_o(cmd_class_i));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // ==========
   // Tasks
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic [4:0] exp_stop(input logic s, d, lv, p);
      if (!s) return 5'h01;
      if (d || lv || !p) return 5'h08;
      return 5'h10;
   endfunction
   task automatic do_reset(input logic p);
      @(negedge clk_i);
      reset_i = 1'b1;
      debug_mode_select_pin_i = p;
      repeat (5) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask
   task automatic op(input int s);
      @(negedge clk_i);
      case (s)
         0: wait_instr_i = 1'b1;
         1: stop_instr_i = 1'b1;
         2: software_breakpoint_instruction_instr_i = 1'b1;
         3: bdc_break_i = 1'b1;
         4: trace_break_i = 1'b1;
         5: irq_pending_i = 1'b1;
         6: rtc_irq_i = 1'b1;
         7: partial_powerdown_ack_i = 1'b1;
         8: ext_irq_pin_i = 1'b1;
         9: port_a_pin_interrupts_i = 8'($random(seed)) | 8'h80;
         10: port_b_pin_interrupts_i = 8'($random(seed)) | 8'h10;
         11: port_d_pin_interrupts_i = 8'($random(seed)) | 8'h02;
         12: lvd_reset_i = 1'b1;
         13: lvw_irq_i = 1'b1;
         14: adc_irq_i = 1'b1;
         default: sci_rx_irq_i = 1'b1;
      endcase
      for (i = 0; i < 12 && s > 7 && mode_o !== 5'h01; i++) @(negedge clk_i);
      if (s < 8) @(negedge clk_i);
      {wait_instr_i, stop_instr_i, software_breakpoint_instruction_instr_i, bdc_break_i, trace_break_i} = '0;
      {irq_pending_i, rtc_irq_i, partial_powerdown_ack_i, ext_irq_pin_i, lvd_reset_i} = '0;
      {lvw_irq_i, adc_irq_i, sci_rx_irq_i} = '0;
      {port_a_pin_interrupts_i, port_b_pin_interrupts_i, port_d_pin_interrupts_i} = '0;
   endtask
   // ==========
   // Scenarios
   initial begin
      seed = 32'h9c2e528e;
      {fails, n_checks} = '0;
      reset_i = 1'b1;
      {debug_mode_select_pin_i, stop_permit_i, debug_permit_i, ref_clk_keep_i} = '0;
      {lowvolt_detect_on_i, lowvolt_in_stop_on_i, partial_powerdown_select_i} = '0;
      irq_vector_i = 16'h0000;
      op(7);
      do_reset(1'b0);
      chk("reset_software_breakpoint_instruction", 5'h02, mode_o);
      chk("suspend", 1'b1, cpu_suspend_o);
      do_reset(1'b1);
      chk("reset_run", 5'h01, mode_o);
      chk("reset_vec", `RESET_VECTOR_ADDR, fetch_addr_o);
      $display("test reset done");
      for (k = 4; k < 10; k++) begin
         debug_permit_i = k[0];
         op(k / 2);
         chk("software_breakpoint_instruction_entry", k[0] ? 5'h02 : 5'h01, mode_o);
         if (k[0]) host_u.send(3'h6);
      end
      for (k = 0; k < 14; k++) begin
         debug_permit_i = k > 6;
         host_u.send(3'(k % 7));
         chk("cmd_accept", k < 4 || k > 6, cmd_accept_o);
         chk("cmd_reject", k > 3 && k < 7, cmd_reject_o);
      end
      chk("go_run", 5'h01, mode_o);
      $display("test commands done");
      op(0);
      chk("wait_mode", 5'h04, mode_o);
      chk("i_bit", 1'b1, clear_i_bit_o);
      chk("cpu_clk", 1'b0, cpu_clk_en_o);
      for (k = 0; k < 7; k++) begin
         if (k == 3) continue;
         host_u.send(3'(k));
         chk("wait_stat", k == 1, cmd_stat_err_o);
         chk("wait_reject", k != 1, cmd_reject_o);
      end
      op(5);
      chk("wait_exit", 5'h01, mode_o);
      chk("stacking", 1'b1, stack_start_o);
      op(0);
      host_u.send(3'h3);
      chk("wait_software_breakpoint_instruction", 5'h02, mode_o);
      host_u.send(3'h6);
      $display("test wait done");
      for (k = 0; k < 24; k++) begin
         {stop_permit_i, debug_permit_i, lowvolt_detect_on_i, lowvolt_in_stop_on_i,
            partial_powerdown_select_i, ref_clk_keep_i} = 6'($random(seed));
         if (k < 2) {stop_permit_i, debug_permit_i, lowvolt_detect_on_i} = {k[0], 2'b00};
         if (k < 2) partial_powerdown_select_i = k[0];
         if (k > 15) {stop_permit_i, debug_permit_i, partial_powerdown_select_i} = 3'b100;
         if (k == 22) {lowvolt_detect_on_i, lowvolt_in_stop_on_i} = 2'b11;
         irq_vector_i = 16'($random(seed));
         d0 = debug_permit_i;
         exp = exp_stop(stop_permit_i, d0, lowvolt_detect_on_i & lowvolt_in_stop_on_i,
            partial_powerdown_select_i);
         op(1);
         chk("stop_mode", exp, mode_o);
         chk("illegal", exp == 5'h01, illegal_op_reset_o);
         if (exp == 5'h01) continue;
         chk("sys_clk", 1'b0, sys_clk_en_o);
         chk("regulator", d0 | (lowvolt_detect_on_i & lowvolt_in_stop_on_i), regulator_full_o);
         chk("bdc_clk", d0, bdc_clk_en_o);
         chk("ref_clk", ref_clk_keep_i, ref_clk_en_o);
         debug_permit_i = ~d0;
         partial_powerdown_select_i = ~partial_powerdown_select_i;
         host_u.send(3'h1);
         chk("stop_held", exp, mode_o);
         chk("stop_stat", exp == 5'h08, cmd_stat_err_o);
         if (exp == 5'h10) begin
            op(6);
            chk("stop2_wake", 5'h01, mode_o);
            chk("wake_reset", 1'b1, cpu_reset_o);
            @(negedge clk_i);
            chk("ppd_flag", 1'b1, partial_powerdown_flag_o);
            chk("pin_latch", 1'b1, pin_latch_o);
            op(7);
            chk("flag_clear", 1'b0, partial_powerdown_flag_o | pin_latch_o);
         end else if (d0) begin
            host_u.send(3'h3);
            chk("stop_software_breakpoint_instruction", 5'h02, mode_o);
            host_u.send(3'h6);
         end else begin
            op(8 + (k % 8));
            chk("stop3_exit", 5'h01, mode_o);
            if (mode_o !== 5'h01) test_done();
            chk("exit_reset", k % 8 == 4, cpu_reset_o);
            chk("exit_fetch", 1'b1, fetch_vector_o);
            chk("exit_addr", k % 8 == 4 ? 16'hfffe : irq_vector_i, fetch_addr_o);
            repeat (5) @(negedge clk_i);
         end
      end
      $display("test stop done");
      test_done();
   end
endmodule // test_operating_mode_controller
